// ==== src/ovrr_defs.svh ====
/*
 Constants of the output voltage reference register bank: register indices,
 reset values, field positions and loop timing.
 Assumes inclusion by bare name from the package and the design modules.
*/
// Function
// R01 - trim top bit selects negative correction
// R02 - trim low seven bits set magnitude
// R03 - channel A upper limit field, default ones
// R04 - channel B upper limit field, default ones
// R05 - channel A lower limit field, default zero
// R06 - channel B lower limit field, default zero
// R07 - channel A reference is high byte plus nibble
// R08 - channel B reference is high byte plus nibble
// R09 - channel A loop drives sense to reference
// R10 - channel B loop drives sense to reference
// R11 - low register upper nibble has no effect
// R12 - clamp reference top six bits within limits
// R13 - reserved bits store and read back
`ifndef OVRR_DEFS_SVH
`define OVRR_DEFS_SVH

// register indices; byte address is four times the index
`define OVRR_IDX_B_TRIM     16'hfe1d
`define OVRR_IDX_A_UPPER    16'hfe1e
`define OVRR_IDX_B_UPPER    16'hfe1f
`define OVRR_IDX_A_LOWER    16'hfe20
`define OVRR_IDX_B_LOWER    16'hfe21
`define OVRR_IDX_A_HIGH     16'hfe22
`define OVRR_IDX_B_HIGH     16'hfe23
`define OVRR_IDX_A_LOW      16'hfe24
`define OVRR_IDX_B_LOW      16'hfe25

// reset values
`define OVRR_RST_TRIM       8'h00
`define OVRR_RST_UPPER      8'h3f
`define OVRR_RST_LOWER      8'h00
`define OVRR_RST_HIGH       8'h00
`define OVRR_RST_LOW        8'h00

// field positions
`define OVRR_TRIM_SIGN_BIT  7
`define OVRR_LIMIT_MSB      5
`define OVRR_LOW_NIB_MSB    3
`define OVRR_REF_W          12
`define OVRR_TRIM_SHIFT     10

// loop update timing
`define OVRR_CLK_PERIOD_NS  50
`define OVRR_LOOP_PERIOD_NS 1000
`define OVRR_LOOP_DIV_CYC   (`OVRR_LOOP_PERIOD_NS / `OVRR_CLK_PERIOD_NS)

`endif

// ==== src/ovrr_pkg.sv ====
/*
 Types shared by the output voltage reference register bank.
 Assumes the constants header is on the include path.
*/
`include "ovrr_defs.svh"

package ovrr_pkg;
	typedef logic [7:0] ovrr_byte_t;
	typedef logic [`OVRR_REF_W-1:0] ovrr_ref_t;
	typedef enum logic [3:0] {
		SLOT_B_TRIM  = 4'h0,
		SLOT_A_UPPER = 4'h1,
		SLOT_B_UPPER = 4'h2,
		SLOT_A_LOWER = 4'h3,
		SLOT_B_LOWER = 4'h4,
		SLOT_A_HIGH  = 4'h5,
		SLOT_B_HIGH  = 4'h6,
		SLOT_A_LOW   = 4'h7,
		SLOT_B_LOW   = 4'h8,
		SLOT_NONE    = 4'hf
	} ovrr_slot_e;
endpackage

// ==== src/ovrr_gain_trim.sv ====
/*
 Gain trim of a voltage sense ADC reading: signed scaling by a 7-bit magnitude.
 Assumes the sense reading is synchronous to the clock; result is registered.
*/
`timescale 1ns/1ns
`include "ovrr_defs.svh"

module ovrr_gain_trim
	import ovrr_pkg::*;
#(
	parameter int SHIFT = `OVRR_TRIM_SHIFT
)
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_b,
	input  wire ovrr_byte_t i_trim,
	input  wire ovrr_ref_t  i_sense,
	output ovrr_ref_t       o_trimmed
);
	generate
		if (SHIFT < 7 || SHIFT > 18)
		begin : g_bad_shift
			$error("trim shift out of range");
		end
	endgenerate

	logic [18:0] prod;
	ovrr_ref_t   corr;
	logic [12:0] sum;
	ovrr_ref_t   next_trimmed;

	// correction scaled down so full magnitude stays a small fraction
	always_comb
	begin
		prod = 19'(i_sense) * 19'(i_trim[6:0]); // R02
		corr = 12'(prod >> SHIFT);
		sum = 13'(i_sense) + 13'(corr);
		if (i_trim[`OVRR_TRIM_SIGN_BIT]) // R01
			next_trimmed = i_sense - corr;
		else
			next_trimmed = sum[12] ? 12'hfff : sum[11:0]; // saturate, no wrap
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_trimmed <= 12'h000;
		else
			o_trimmed <= next_trimmed;
	end

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);

	trim_polarity_a: assert property ( // R01
		i_trim[7] |=> (o_trimmed <= $past(i_sense)))
		else $error("negative trim raised the reading");
	trim_zero_a: assert property ( // R02
		(i_trim[6:0] == 7'h00) |=> (o_trimmed == $past(i_sense)))
		else $error("zero trim changed the reading");
endmodule

// ==== src/ovrr_chan_loop.sv ====
/*
 One regulated channel: clamps the programmed reference between its limit
 fields and steps a duty command so the sense reading meets the reference.
 Assumes i_step is a one-cycle enable pulse from a divider.
*/
`timescale 1ns/1ns
`include "ovrr_defs.svh"

module ovrr_chan_loop
	import ovrr_pkg::*;
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_step,
	input  wire ovrr_ref_t  i_ref_raw,
	input  wire logic [5:0] i_lower,
	input  wire logic [5:0] i_upper,
	input  wire ovrr_ref_t  i_sense,
	output ovrr_ref_t       o_ref,
	output ovrr_ref_t       o_duty
);
	ovrr_ref_t next_ref;
	ovrr_ref_t next_duty;

	// lower applied first so upper wins if limits cross
	always_comb
	begin
		next_ref = i_ref_raw;
		if (i_ref_raw[11:6] < i_lower) // R12
			next_ref = {i_lower, 6'h00};
		if (next_ref[11:6] > i_upper) // R12
			next_ref = {i_upper, 6'h3f};
		next_duty = o_duty;
		if (i_step && i_sense < o_ref && o_duty != 12'hfff) // R09 R10
			next_duty = o_duty + 12'h001;
		else if (i_step && i_sense > o_ref && o_duty != 12'h000)
			next_duty = o_duty - 12'h001;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_ref <= 12'h000;
			o_duty <= 12'h000;
		end
		else
		begin
			o_ref <= next_ref;
			o_duty <= next_duty;
		end
	end

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);

	clamp_upper_a: assert property ( // R12
		1'b1 |=> (o_ref[11:6] <= $past(i_upper)))
		else $error("reference above upper limit");
	clamp_lower_a: assert property ( // R12
		($past(i_lower) <= $past(i_upper)) |-> (o_ref[11:6] >= $past(i_lower)))
		else $error("reference below lower limit");
	loop_step_a: assert property ( // R09
		(i_step && i_sense < o_ref && o_duty != 12'hfff)
		|=> (o_duty == $past(o_duty) + 12'h001))
		else $error("duty did not rise toward reference");
endmodule

// ==== src/ovrr_regs.sv ====
/*
 Output voltage reference register bank for two regulated channels, an
 AHB-Lite slave. Holds the gain trim, limit and reference registers and
 runs a clamped reference and a stepping loop per channel.
 Assumes a single AHB-Lite master, word transfers, synchronous ADC inputs.
*/
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ns
`include "ovrr_defs.svh"

module ovrr_regs
	import ovrr_pkg::*;
#(
	parameter int LOOP_DIV = `OVRR_LOOP_DIV_CYC
)
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_hsel,
	input  wire logic [17:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	input  wire ovrr_ref_t   i_chan_a_voltage_sense_adc,
	input  wire ovrr_ref_t   i_chan_b_voltage_sense_adc,
	output ovrr_ref_t        o_chan_a_reference,
	output ovrr_ref_t        o_chan_b_reference,
	output ovrr_ref_t        o_chan_a_duty,
	output ovrr_ref_t        o_chan_b_duty
);
	generate
		if (LOOP_DIV < 1 || LOOP_DIV > 65535)
		begin : g_bad_div
			$error("loop divider out of range");
		end
	endgenerate

	localparam int NSLOT = 9;
	localparam ovrr_byte_t RST_VAL [0:NSLOT-1] = '{
		`OVRR_RST_TRIM, `OVRR_RST_UPPER, `OVRR_RST_UPPER,
		`OVRR_RST_LOWER, `OVRR_RST_LOWER, `OVRR_RST_HIGH,
		`OVRR_RST_HIGH, `OVRR_RST_LOW, `OVRR_RST_LOW
	};

	// word index decode, shared by the write and read paths
	function automatic ovrr_slot_e slot_of(input logic [17:0] addr);
		case (addr[17:2])
			`OVRR_IDX_B_TRIM:  slot_of = SLOT_B_TRIM;
			`OVRR_IDX_A_UPPER: slot_of = SLOT_A_UPPER;
			`OVRR_IDX_B_UPPER: slot_of = SLOT_B_UPPER;
			`OVRR_IDX_A_LOWER: slot_of = SLOT_A_LOWER;
			`OVRR_IDX_B_LOWER: slot_of = SLOT_B_LOWER;
			`OVRR_IDX_A_HIGH:  slot_of = SLOT_A_HIGH;
			`OVRR_IDX_B_HIGH:  slot_of = SLOT_B_HIGH;
			`OVRR_IDX_A_LOW:   slot_of = SLOT_A_LOW;
			`OVRR_IDX_B_LOW:   slot_of = SLOT_B_LOW;
			default:           slot_of = SLOT_NONE;
		endcase
	endfunction

	ovrr_byte_t regs [0:NSLOT-1];
	ovrr_byte_t next_regs [0:NSLOT-1];
	logic       wr_pend;
	logic       next_wr_pend;
	ovrr_slot_e wr_slot;
	ovrr_slot_e next_wr_slot;
	logic       addr_ok;
	ovrr_slot_e addr_slot;

	// address phase: only NONSEQ/SEQ with hready high is taken
	always_comb
	begin
		addr_ok = i_hsel && i_htrans[1] && i_hready;
		addr_slot = slot_of(i_haddr);
		next_wr_pend = addr_ok && i_hwrite;
		next_wr_slot = addr_ok ? addr_slot : SLOT_NONE;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			wr_pend <= 1'b0;
			wr_slot <= SLOT_NONE;
		end
		else
		begin
			wr_pend <= next_wr_pend;
			wr_slot <= next_wr_slot;
		end
	end

	// data phase write; full byte stored, reserved bits included
	always_comb
	begin
		for (int i = 0; i < NSLOT; i++)
			next_regs[i] = regs[i];
		if (wr_pend && wr_slot != SLOT_NONE)
			next_regs[wr_slot] = i_hwdata[7:0]; // R13
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			for (int i = 0; i < NSLOT; i++)
				regs[i] <= RST_VAL[i]; // R03 R04 R05 R06
		end
		else
		begin
			for (int i = 0; i < NSLOT; i++)
				regs[i] <= next_regs[i];
		end
	end

	logic [31:0] next_hrdata;

	// read data taken from next values so a write just ahead is seen
	always_comb
	begin
		next_hrdata = o_hrdata;
		if (addr_ok && !i_hwrite)
		begin
			if (addr_slot == SLOT_NONE)
				next_hrdata = 32'h0000_0000; // unmapped reads zero
			else
				next_hrdata = {24'h00_0000, next_regs[addr_slot]}; // R13
		end
	end

	// zero wait states, always OKAY; flops keep outputs glitch free
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_hrdata <= 32'h0000_0000;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end
		else
		begin
			o_hrdata <= next_hrdata;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end
	end

	logic [15:0] div_cnt;
	logic [15:0] next_div_cnt;
	logic        step;
	logic        next_step;

	// loop update enable; slow rate keeps the step loop quiet
	always_comb
	begin
		next_step = (div_cnt == 16'(LOOP_DIV - 1));
		next_div_cnt = next_step ? 16'h0000 : div_cnt + 16'h0001;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			div_cnt <= 16'h0000;
			step <= 1'b0;
		end
		else
		begin
			div_cnt <= next_div_cnt;
			step <= next_step;
		end
	end

	ovrr_ref_t ref_raw_a;
	ovrr_ref_t ref_raw_b;
	ovrr_ref_t sense_b_trimmed;

	// only the low nibble feeds the reference
	assign ref_raw_a = {regs[SLOT_A_HIGH], regs[SLOT_A_LOW][3:0]}; // R07 R11
	assign ref_raw_b = {regs[SLOT_B_HIGH], regs[SLOT_B_LOW][3:0]}; // R08 R11

	// channel B sense is trimmed; costs one cycle of loop latency
	ovrr_gain_trim u_trim_b (
		.i_sys_clk (i_sys_clk),
		.i_rst_b   (i_rst_b),
		.i_trim    (regs[SLOT_B_TRIM]),
		.i_sense   (i_chan_b_voltage_sense_adc),
		.o_trimmed (sense_b_trimmed)
	);

	ovrr_chan_loop u_loop_a (
		.i_sys_clk (i_sys_clk),
		.i_rst_b   (i_rst_b),
		.i_step    (step),
		.i_ref_raw (ref_raw_a),
		.i_lower   (regs[SLOT_A_LOWER][5:0]),
		.i_upper   (regs[SLOT_A_UPPER][5:0]),
		.i_sense   (i_chan_a_voltage_sense_adc),
		.o_ref     (o_chan_a_reference),
		.o_duty    (o_chan_a_duty)
	);

	ovrr_chan_loop u_loop_b (
		.i_sys_clk (i_sys_clk),
		.i_rst_b   (i_rst_b),
		.i_step    (step),
		.i_ref_raw (ref_raw_b),
		.i_lower   (regs[SLOT_B_LOWER][5:0]),
		.i_upper   (regs[SLOT_B_UPPER][5:0]),
		.i_sense   (sense_b_trimmed),
		.o_ref     (o_chan_b_reference),
		.o_duty    (o_chan_b_duty)
	);

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);

	upper_default_a: assert property ( // R03 R04
		$rose(i_rst_b) |-> (regs[SLOT_A_UPPER][5:0] == 6'h3f
			&& regs[SLOT_B_UPPER][5:0] == 6'h3f))
		else $error("upper limit default wrong");
	lower_default_a: assert property ( // R05 R06
		$rose(i_rst_b) |-> (regs[SLOT_A_LOWER][5:0] == 6'h00
			&& regs[SLOT_B_LOWER][5:0] == 6'h00))
		else $error("lower limit default wrong");
	ref_pass_a_a: assert property ( // R07
		(regs[SLOT_A_LOWER][5:0] == 6'h00 && regs[SLOT_A_UPPER][5:0] == 6'h3f)
		|=> (o_chan_a_reference == {$past(regs[SLOT_A_HIGH]),
			$past(regs[SLOT_A_LOW][3:0])}))
		else $error("channel A reference not formed from its registers");
	ref_pass_b_a: assert property ( // R08
		(regs[SLOT_B_LOWER][5:0] == 6'h00 && regs[SLOT_B_UPPER][5:0] == 6'h3f)
		|=> (o_chan_b_reference == {$past(regs[SLOT_B_HIGH]),
			$past(regs[SLOT_B_LOW][3:0])}))
		else $error("channel B reference not formed from its registers");
	write_readback_a: assert property ( // R13
		(wr_pend && wr_slot != SLOT_NONE && addr_ok && !i_hwrite
			&& addr_slot == wr_slot)
		|=> (o_hrdata == {24'h00_0000, $past(i_hwdata[7:0])}))
		else $error("written byte not read back");
	loop_b_step_a: assert property ( // R10
		(step && sense_b_trimmed > o_chan_b_reference && o_chan_b_duty != 12'h000)
		|=> (o_chan_b_duty == $past(o_chan_b_duty) - 12'h001))
		else $error("channel B duty did not fall toward reference");

	// every slot takes the data phase byte aimed at it and nothing else
	generate
		for (genvar g = 0; g < NSLOT; g++)
		begin : g_slot_chk
			slot_write_a: assert property ( // R13
				@(posedge i_sys_clk) disable iff (!i_rst_b)
				(wr_pend && wr_slot == ovrr_slot_e'(g))
				|=> (regs[g] == $past(i_hwdata[7:0])))
				else $error("register slot missed its write");
			slot_keep_a: assert property ( // R13
				@(posedge i_sys_clk) disable iff (!i_rst_b)
				!(wr_pend && wr_slot == ovrr_slot_e'(g)) |=> $stable(regs[g]))
				else $error("register slot changed without a write");
		end
	endgenerate

	// read data is the addressed byte unless a write to it is in flight
	read_data_a: assert property ( // R13
		(addr_ok && !i_hwrite && addr_slot != SLOT_NONE
			&& !(wr_pend && wr_slot == addr_slot))
		|=> (o_hrdata == {24'h00_0000, $past(regs[addr_slot])}))
		else $error("read data not the addressed register");
	unmapped_read_a: assert property (
		(addr_ok && !i_hwrite && addr_slot == SLOT_NONE)
		|=> (o_hrdata == 32'h0000_0000))
		else $error("unmapped read not zero");
	// read data stands until the next read is taken
	read_hold_a: assert property (
		!(addr_ok && !i_hwrite) |=> $stable(o_hrdata))
		else $error("read data moved without a read");

	// reserved upper nibble of a low register never reaches the reference
	low_nibble_a_a: assert property ( // R11
		($stable(regs[SLOT_A_HIGH]) && $stable(regs[SLOT_A_LOW][3:0])
			&& $stable(regs[SLOT_A_LOWER]) && $stable(regs[SLOT_A_UPPER]))
		|=> $stable(o_chan_a_reference))
		else $error("reserved bits moved channel A reference");
	low_nibble_b_a: assert property ( // R11
		($stable(regs[SLOT_B_HIGH]) && $stable(regs[SLOT_B_LOW][3:0])
			&& $stable(regs[SLOT_B_LOWER]) && $stable(regs[SLOT_B_UPPER]))
		|=> $stable(o_chan_b_reference))
		else $error("reserved bits moved channel B reference");

	// duty only moves on a loop tick, and rests once sense meets reference
	duty_hold_a: assert property ( // R09 R10
		!step |=> ($stable(o_chan_a_duty) && $stable(o_chan_b_duty)))
		else $error("duty moved between loop ticks");
	loop_a_hold_a: assert property ( // R09
		(step && i_chan_a_voltage_sense_adc == o_chan_a_reference)
		|=> $stable(o_chan_a_duty))
		else $error("channel A duty moved at reference");
	loop_a_fall_a: assert property ( // R09
		(step && i_chan_a_voltage_sense_adc > o_chan_a_reference
			&& o_chan_a_duty != 12'h000)
		|=> (o_chan_a_duty == $past(o_chan_a_duty) - 12'h001))
		else $error("channel A duty did not fall toward reference");
	loop_b_hold_a: assert property ( // R10
		(step && sense_b_trimmed == o_chan_b_reference)
		|=> $stable(o_chan_b_duty))
		else $error("channel B duty moved at reference");
endmodule

// ==== dv/ovrr_regs_tb_top.sv ====
/*
 Self-checking testbench of the output voltage reference register bank.
 Assumes the defs header on the include path and one AHB-Lite slave on the bus.
*/
`timescale 1ns/1ns
`include "ovrr_defs.svh"

module ovrr_regs_tb_top
	import ovrr_pkg::*;
;
	localparam int LOOP_DIV_TB = 2;
	localparam int RUN_CYC     = 40;
	localparam int STEPS       = RUN_CYC / LOOP_DIV_TB;

	logic        sys_clk;
	logic        rst_b;
	logic        hsel;
	logic [17:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	ovrr_ref_t   sense_a;
	ovrr_ref_t   sense_b;
	ovrr_ref_t   ref_a;
	ovrr_ref_t   ref_b;
	ovrr_ref_t   duty_a;
	ovrr_ref_t   duty_b;
	int          miscompares;
	int          tests_run;
	int          cycles;
	logic [15:0] idx_tab [9];
	logic [7:0]  rst_tab [9];

	ovrr_regs #(.LOOP_DIV(LOOP_DIV_TB)) dut (
		.i_sys_clk                  (sys_clk),
		.i_rst_b                    (rst_b),
		.i_hsel                     (hsel),
		.i_haddr                    (haddr),
		.i_htrans                   (htrans),
		.i_hwrite                   (hwrite),
		.i_hsize                    (3'h2),
		.i_hwdata                   (hwdata),
		.i_hready                   (hreadyout),
		.o_hrdata                   (hrdata),
		.o_hreadyout                (hreadyout),
		.o_hresp                    (hresp),
		.i_chan_a_voltage_sense_adc (sense_a),
		.i_chan_b_voltage_sense_adc (sense_b),
		.o_chan_a_reference         (ref_a),
		.o_chan_b_reference         (ref_b),
		.o_chan_a_duty              (duty_a),
		.o_chan_b_duty              (duty_b)
	);

	// free-running system clock
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			conclude();
		end
	end

	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one single word transfer; waits on hready, never a fixed count
	task automatic ahb(logic wr, logic [15:0] idx, logic [31:0] wd, output logic [31:0] rd);
		@(posedge sys_clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr  <= {idx, 2'b00};
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic wr(logic [15:0] idx, logic [7:0] d);
		logic [31:0] unused;
		ahb(1'b1, idx, {24'hffffff, d}, unused);
	endtask

	task automatic rd_chk(string name, logic [15:0] idx, logic [7:0] exp);
		logic [31:0] got;
		ahb(1'b0, idx, 32'h0, got);
		chk(name, {24'h0, exp}, got);
	endtask

	// lets a register write reach the reference outputs, samples mid-cycle
	task automatic ref_chk(ovrr_ref_t exp_a, ovrr_ref_t exp_b);
		repeat (3) @(negedge sys_clk);
		chk("ref a", {20'h0, exp_a}, {20'h0, ref_a});
		chk("ref b", {20'h0, exp_b}, {20'h0, ref_b});
	endtask

	// reset values of every register, unmapped word reads zero
	task automatic t_reset_values();
		for (int i = 0; i < 9; i++)
			rd_chk("reset value", idx_tab[i], rst_tab[i]);
		rd_chk("unmapped", 16'hfe26, 8'h00);
		chk("ref a rst", 32'h0, {20'h0, ref_a});
	endtask

	// full bytes, reserved bits included, store and read back; then restore
	task automatic t_readback();
		for (int i = 0; i < 9; i++)
		begin
			wr(idx_tab[i], 8'ha5 ^ 8'(i));
			rd_chk("readback", idx_tab[i], 8'ha5 ^ 8'(i));
		end
		wr(16'hfe26, 8'h77);
		rd_chk("unmapped wr", 16'hfe26, 8'h00);
		for (int i = 0; i < 9; i++)
			wr(idx_tab[i], rst_tab[i]);
	endtask

	// twelve-bit reference from high byte and low nibble, clamp boundaries
	task automatic t_reference();
		wr(`OVRR_IDX_A_HIGH, 8'hab);
		wr(`OVRR_IDX_A_LOW, 8'hf5);
		wr(`OVRR_IDX_B_HIGH, 8'h3c);
		wr(`OVRR_IDX_B_LOW, 8'h97);
		ref_chk(12'hab5, 12'h3c7);
		wr(`OVRR_IDX_A_LOW, 8'h05);
		wr(`OVRR_IDX_B_LOW, 8'h37);
		ref_chk(12'hab5, 12'h3c7);
		wr(`OVRR_IDX_A_LOWER, 8'h30);
		wr(`OVRR_IDX_B_LOWER, 8'h10);
		ref_chk(12'hc00, 12'h400);
		wr(`OVRR_IDX_A_LOWER, 8'h00);
		wr(`OVRR_IDX_A_UPPER, 8'h20);
		wr(`OVRR_IDX_B_LOWER, 8'h0f);
		ref_chk(12'h83f, 12'h3c7);
		wr(`OVRR_IDX_B_UPPER, 8'h0e);
		ref_chk(12'h83f, 12'h3bf);
		wr(`OVRR_IDX_A_UPPER, 8'h3f);
		wr(`OVRR_IDX_B_UPPER, 8'h3f);
		wr(`OVRR_IDX_B_LOWER, 8'h00);
	endtask

	// duty must move by exactly one step per tick, direction set by sense
	task automatic run_loop(logic chan_b, int delta);
		ovrr_ref_t d0;
		ovrr_ref_t d1;
		repeat (4) @(negedge sys_clk);
		d0 = chan_b ? duty_b : duty_a;
		repeat (RUN_CYC) @(negedge sys_clk);
		d1 = chan_b ? duty_b : duty_a;
		chk(chan_b ? "duty b" : "duty a", {20'h0, d0 + 12'(delta)}, {20'h0, d1});
	endtask

	task automatic t_loop_a();
		wr(`OVRR_IDX_A_HIGH, 8'h10);
		wr(`OVRR_IDX_A_LOW, 8'hf0);
		ref_chk(12'h100, 12'h3c7);
		@(posedge sys_clk);
		sense_a <= 12'h080;
		run_loop(1'b0, STEPS);
		@(posedge sys_clk);
		sense_a <= 12'h100;
		run_loop(1'b0, 0);
		@(posedge sys_clk);
		sense_a <= 12'h180;
		run_loop(1'b0, -STEPS);
	endtask

	// trimmed b reading: 0x800 corrected by 0x800*mag/1024 against 0x880
	task automatic t_loop_b();
		logic [7:0] trims  [4];
		int         deltas [4];
		trims  = '{8'hff, 8'h00, 8'h40, 8'h7f};
		deltas = '{STEPS, STEPS, 0, -STEPS};
		wr(`OVRR_IDX_B_HIGH, 8'h88);
		wr(`OVRR_IDX_B_LOW, 8'h00);
		ref_chk(12'h100, 12'h880);
		@(posedge sys_clk);
		sense_b <= 12'h800;
		for (int i = 0; i < 4; i++)
		begin
			wr(`OVRR_IDX_B_TRIM, trims[i]);
			run_loop(1'b1, deltas[i]);
		end
	endtask

	// main sequence
	initial
	begin
		idx_tab = '{`OVRR_IDX_B_TRIM, `OVRR_IDX_A_UPPER, `OVRR_IDX_B_UPPER,
			`OVRR_IDX_A_LOWER, `OVRR_IDX_B_LOWER, `OVRR_IDX_A_HIGH,
			`OVRR_IDX_B_HIGH, `OVRR_IDX_A_LOW, `OVRR_IDX_B_LOW};
		rst_tab = '{`OVRR_RST_TRIM, `OVRR_RST_UPPER, `OVRR_RST_UPPER,
			`OVRR_RST_LOWER, `OVRR_RST_LOWER, `OVRR_RST_HIGH,
			`OVRR_RST_HIGH, `OVRR_RST_LOW, `OVRR_RST_LOW};
		miscompares = 0;
		tests_run   = 0;
		cycles      = 0;
		rst_b       = 1'b0;
		hsel        = 1'b0;
		haddr       = 18'h0;
		htrans      = 2'h0;
		hwrite      = 1'b0;
		hwdata      = 32'h0;
		sense_a     = 12'h000;
		sense_b     = 12'h000;
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_reset_values();
		t_readback();
		t_reference();
		t_loop_a();
		t_loop_b();
		conclude();
	end
endmodule
